// ==== design/arz_pkg.sv ====
// Purpose: Shared constants for the autoreclose zone-follow sequencer
// Assumes: 125 MHz system clock, word-addressed byte offsets on the register port
// Notes:   All timer values are in milliseconds of the common timebase
package arz_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] BKR_SUP_MS   = 16'h00C8;
  localparam logic [15:0] CLOSE_SUP_MS = 16'h0064;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;
  localparam logic [7:0] ADDR_DEAD0  = 8'h10;
  localparam logic [7:0] ADDR_MBLK   = 8'h20;
  localparam logic [7:0] ADDR_RECL   = 8'h24;
  localparam logic [7:0] ADDR_INIT   = 8'h28;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN    = 0;
  localparam int CTRL_ZONE  = 1;
  localparam int CTRL_MAX_L = 2;
  localparam int CTRL_LORST = 7;
  localparam int ST_SUCCESS = 0;
  localparam int ST_FAILED  = 1;
  localparam int ST_LOCKOUT = 2;
  localparam int ST_SHOT    = 3;
  localparam int NUM_SHOTS  = 4;
  localparam int NUM_INIT   = 4;
  localparam logic [4:0]  CTRL_RST = 5'h05;
  localparam logic [15:0] DEAD_RST = 16'h01F4;
  localparam logic [15:0] MBLK_RST = 16'h03E8;
  localparam logic [15:0] RECL_RST = 16'h2710;
  localparam logic [15:0] INIT_RST = 16'hFFFF;

  typedef enum logic [8:0] {
    ARZ_STANDBY = 9'h001,
    ARZ_MANBLK  = 9'h002,
    ARZ_READY   = 9'h004,
    ARZ_RUN     = 9'h008,
    ARZ_WAITOPN = 9'h010,
    ARZ_DEAD    = 9'h020,
    ARZ_RECLOSE = 9'h040,
    ARZ_RECLAIM = 9'h080,
    ARZ_LOCKOUT = 9'h100
  } arz_state_t;
endpackage

// ==== design/arz_tick.sv ====
// Purpose: Millisecond tick from the system clock
// Assumes: Single clock domain
// Notes:   One-cycle pulse every TICK_CYCLES clocks
`timescale 1ns/1ns
module arz_tick #(
  parameter int TICK_CYCLES = arz_pkg::MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic clear,
  output logic      tick
);
  logic [16:0] cnt_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 17'h00000;
      tick    <= 1'b0;
    end
    else if (clear || cnt_reg == 17'(TICK_CYCLES - 1))
    begin
      cnt_reg <= 17'h00000;
      tick    <= !clear;
    end
    else
    begin
      cnt_reg <= cnt_reg + 17'h00001;
      tick    <= 1'b0;
    end
  end
endmodule

// ==== design/arz_timer.sv ====
// Purpose: Millisecond down-counter used for every sequence timer
// Assumes: tick is a one-cycle pulse from the common timebase
// Notes:   A load of zero still waits one tick; start restarts a running timer
`timescale 1ns/1ns
module arz_timer (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic [15:0] load,
  output logic             running,
  output logic             expired
);
  logic [15:0] cnt_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 16'h0000;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (clear)
    begin
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= (load == 16'h0000) ? 16'h0001 : load;
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (running && tick)
    begin
      cnt_reg <= cnt_reg - 16'h0001;
      running <= (cnt_reg != 16'h0001);
      expired <= (cnt_reg == 16'h0001);
    end
    else
    begin
      expired <= 1'b0;
    end
  end
endmodule

// ==== design/arz_seq.sv ====
// Purpose: Autoreclose sequencer with manual-close block and zone following
// Assumes: Breaker and protection inputs synchronous to clock
// Notes:   Registers reached over a plain strobe port, read data one cycle later
// Overview of operation
// - Trips pass during manual block; timer continues
// - Block expiry with breaker open returns standby
// - Zone following enabled by its own control bit
// - Zone mode reuses shots, dead times, initiators, timers
// - Zone mode starts dead time without own trip
// - Zone mode dead timer starts on initiator pickup dropout
// - Zone mode dead expiry counts shot, starts reclaim, no close
// - Shot number output selects protection settings
// - No renewed fault: reset after reclaim expiry
// - Manual close starts block timer, then ready
// - Breaker must open within 200 ms supervision
// - Quiet reclaim returns ready and flags success
// - Recurring fault reruns; shots exhausted lock out
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module arz_seq #(
  parameter int TICK_CYCLES = arz_pkg::MS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        gen_reset,
  input  wire logic        breaker_closed,
  input  wire logic        ext_block,
  input  wire logic [3:0]  pickup,
  input  wire logic [3:0]  trip,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             trip_cmd,
  output logic             close_cmd,
  output logic      [2:0]  shot_num,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] shot_nib(input logic [15:0] v, input logic [1:0] i);
    shot_nib = v[4*i +: 4];
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0]  ctrl_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [15:0] dead_reg [arz_pkg::NUM_SHOTS];
  logic [15:0] mblk_reg;
  logic [15:0] recl_reg;
  logic [15:0] init_reg;
  logic        closed_reg;
  logic [2:0]  shot_reg;
  arz_pkg::arz_state_t state_reg;
  arz_pkg::arz_state_t state_next;

  logic        tick;
  logic        tmr_start;
  logic [15:0] tmr_load;
  logic        tmr_run;
  logic        tmr_exp;
  logic        mblk_start;
  logic        mblk_run;
  logic        mblk_exp;
  logic        close_evt;
  logic        ok;
  logic        zone;
  logic        init_pu;
  logic        init_tr;
  logic        shots_used;
  logic        lo_reset;
  logic        ev_success;
  logic        ev_failed;
  logic        ev_lockout;
  logic        ev_shot;
  logic [3:0]  ev_set;

  assign zone       = ctrl_reg[arz_pkg::CTRL_ZONE];
  assign ok         = ctrl_reg[arz_pkg::CTRL_EN] && !ext_block && !gen_reset;
  assign close_evt  = breaker_closed && !closed_reg;
  assign init_pu    = |(pickup & shot_nib(init_reg, shot_reg[1:0]));
  assign init_tr    = |(trip & shot_nib(init_reg, shot_reg[1:0]));
  assign shots_used = shot_reg >= ctrl_reg[arz_pkg::CTRL_MAX_L +: 3];
  assign lo_reset   = wr && hit(addr, arz_pkg::ADDR_CTRL) && wdata[arz_pkg::CTRL_LORST];

  // ----------------------------------------------------------------
  // Timebase and timers
  // ----------------------------------------------------------------
  arz_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock (clock),
    .rstn  (rstn),
    .clear (gen_reset),
    .tick  (tick)
  );

  arz_timer u_seq_tmr (
    .clock   (clock),
    .rstn    (rstn),
    .clear   (gen_reset),
    .tick    (tick),
    .start   (tmr_start),
    .load    (tmr_load),
    .running (tmr_run),
    .expired (tmr_exp)
  );

  // Kept separate so a trip never restarts or cancels the block interval
  arz_timer u_mblk_tmr (
    .clock   (clock),
    .rstn    (rstn),
    .clear   (gen_reset),
    .tick    (tick),
    .start   (mblk_start),
    .load    (mblk_reg),
    .running (mblk_run),
    .expired (mblk_exp)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    tmr_start  = 1'b0;
    tmr_load   = arz_pkg::BKR_SUP_MS;
    mblk_start = 1'b0;
    ev_success = 1'b0;
    ev_failed  = 1'b0;
    ev_shot    = 1'b0;
    case (state_reg)
      arz_pkg::ARZ_STANDBY:
      begin
        if (close_evt)
        begin
          mblk_start = 1'b1;
          state_next = arz_pkg::ARZ_MANBLK;
        end
      end
      arz_pkg::ARZ_MANBLK:
      begin
        if (mblk_exp)
          state_next = breaker_closed ? arz_pkg::ARZ_READY : arz_pkg::ARZ_STANDBY;
      end
      arz_pkg::ARZ_READY:
      begin
        if (!breaker_closed)
          state_next = arz_pkg::ARZ_STANDBY;
        else if (init_pu || init_tr)
          state_next = arz_pkg::ARZ_RUN;
      end
      arz_pkg::ARZ_RUN:
      begin
        if (init_tr)
        begin
          tmr_start  = 1'b1;
          state_next = arz_pkg::ARZ_WAITOPN;
        end
        else if (zone && !init_pu)
        begin
          tmr_start  = 1'b1;
          tmr_load   = dead_reg[shot_reg[1:0]];
          state_next = arz_pkg::ARZ_DEAD;
        end
      end
      arz_pkg::ARZ_WAITOPN:
      begin
        if (!breaker_closed)
        begin
          tmr_start  = 1'b1;
          tmr_load   = dead_reg[shot_reg[1:0]];
          state_next = arz_pkg::ARZ_DEAD;
        end
        else if (tmr_exp)
        begin
          ev_failed  = 1'b1;
          state_next = arz_pkg::ARZ_LOCKOUT;
        end
      end
      arz_pkg::ARZ_DEAD:
      begin
        if (tmr_exp)
        begin
          ev_shot   = 1'b1;
          tmr_start = 1'b1;
          if (zone)
          begin
            tmr_load   = recl_reg;
            state_next = arz_pkg::ARZ_RECLAIM;
          end
          else
          begin
            tmr_load   = arz_pkg::CLOSE_SUP_MS;
            state_next = arz_pkg::ARZ_RECLOSE;
          end
        end
      end
      arz_pkg::ARZ_RECLOSE:
      begin
        if (breaker_closed)
        begin
          tmr_start  = 1'b1;
          tmr_load   = recl_reg;
          state_next = arz_pkg::ARZ_RECLAIM;
        end
        else if (tmr_exp)
        begin
          ev_failed  = 1'b1;
          state_next = arz_pkg::ARZ_LOCKOUT;
        end
      end
      arz_pkg::ARZ_RECLAIM:
      begin
        if (init_pu || init_tr)
        begin
          ev_failed  = shots_used;
          state_next = shots_used ? arz_pkg::ARZ_LOCKOUT : arz_pkg::ARZ_RUN;
        end
        else if (tmr_exp)
        begin
          ev_success = 1'b1;
          state_next = arz_pkg::ARZ_READY;
        end
      end
      arz_pkg::ARZ_LOCKOUT:
      begin
        if (lo_reset)
          state_next = arz_pkg::ARZ_STANDBY;
      end
      default:
        state_next = arz_pkg::ARZ_STANDBY;
    endcase
    // Blocking or a disabled function parks the sequencer without lockout
    if (!ok && state_reg != arz_pkg::ARZ_LOCKOUT)
    begin
      state_next = arz_pkg::ARZ_STANDBY;
      tmr_start  = 1'b0;
      mblk_start = 1'b0;
      ev_success = 1'b0;
      ev_failed  = 1'b0;
      ev_shot    = 1'b0;
    end
    if (gen_reset)
      state_next = arz_pkg::ARZ_STANDBY;
  end

  assign ev_lockout = ev_failed;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_reg <= arz_pkg::ARZ_STANDBY;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      closed_reg <= 1'b0;
    else
      closed_reg <= breaker_closed;
  end

  // Shot counter advances before any close so settings track the shot
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      shot_reg <= 3'h0;
    else if (gen_reset || state_next == arz_pkg::ARZ_READY || state_next == arz_pkg::ARZ_STANDBY)
      shot_reg <= 3'h0;
    else if (ev_shot)
      shot_reg <= shot_reg + 3'h1;
  end

  // ----------------------------------------------------------------
  // Outputs to breaker and protection
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      trip_cmd  <= 1'b0;
      close_cmd <= 1'b0;
      shot_num  <= 3'h0;
    end
    else
    begin
      trip_cmd  <= |trip;
      close_cmd <= ev_shot && !zone && ok;
      shot_num  <= shot_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= arz_pkg::CTRL_RST;
      mask_reg <= 4'h0;
      mblk_reg <= arz_pkg::MBLK_RST;
      recl_reg <= arz_pkg::RECL_RST;
      init_reg <= arz_pkg::INIT_RST;
    end
    else if (wr)
    begin
      if (hit(addr, arz_pkg::ADDR_CTRL))
        ctrl_reg <= wdata[4:0];
      if (hit(addr, arz_pkg::ADDR_MASK))
        mask_reg <= wdata[3:0];
      if (hit(addr, arz_pkg::ADDR_MBLK))
        mblk_reg <= wdata[15:0];
      if (hit(addr, arz_pkg::ADDR_RECL))
        recl_reg <= wdata[15:0];
      if (hit(addr, arz_pkg::ADDR_INIT))
        init_reg <= wdata[15:0];
    end
  end

  generate
    for (genvar g = 0; g < arz_pkg::NUM_SHOTS; g++)
    begin : g_dead
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          dead_reg[g] <= arz_pkg::DEAD_RST;
        else if (wr && hit(addr, arz_pkg::ADDR_DEAD0 + 8'(4 * g)))
          dead_reg[g] <= wdata[15:0];
      end
    end
  endgenerate

  assign ev_set = {ev_shot, ev_lockout, ev_failed, ev_success};

  // Write one to clear; a same-cycle event still wins
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      status_reg <= 4'h0;
    else if (wr && hit(addr, arz_pkg::ADDR_STATUS))
      status_reg <= (status_reg & ~wdata[3:0]) | ev_set;
    else
      status_reg <= status_reg | ev_set;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h00000000;
    else if (!rd)
      rdata <= 32'h00000000;
    else
      case (addr)
        arz_pkg::ADDR_CTRL:   rdata <= {27'h0, ctrl_reg};
        arz_pkg::ADDR_STATUS: rdata <= {28'h0, status_reg};
        arz_pkg::ADDR_MASK:   rdata <= {28'h0, mask_reg};
        arz_pkg::ADDR_STATE:  rdata <= {18'h0, mblk_run, tmr_run, shot_reg, state_reg};
        arz_pkg::ADDR_MBLK:   rdata <= {16'h0, mblk_reg};
        arz_pkg::ADDR_RECL:   rdata <= {16'h0, recl_reg};
        arz_pkg::ADDR_INIT:   rdata <= {16'h0, init_reg};
        arz_pkg::ADDR_DEAD0:  rdata <= {16'h0, dead_reg[0]};
        8'h14:                rdata <= {16'h0, dead_reg[1]};
        8'h18:                rdata <= {16'h0, dead_reg[2]};
        8'h1C:                rdata <= {16'h0, dead_reg[3]};
        default:              rdata <= 32'h00000000;
      endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  trip_passes_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_MANBLK && |trip |=> trip_cmd)
    else $error("trip not passed during manual block");

  mblk_continues_a: assert property (@(posedge clock) disable iff (!rstn)
    mblk_run && !mblk_exp && |trip && !gen_reset |=> mblk_run || mblk_exp)
    else $error("manual block timer stopped by trip");

  mblk_open_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_MANBLK && mblk_exp && !breaker_closed
    |=> state_reg == arz_pkg::ARZ_STANDBY)
    else $error("open breaker after block did not return standby");

  manual_close_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_STANDBY && close_evt && ok
    |=> state_reg == arz_pkg::ARZ_MANBLK && mblk_run)
    else $error("manual close did not start block");

  zone_dead_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_RUN && zone && ok && !init_pu && !init_tr
    |=> state_reg == arz_pkg::ARZ_DEAD && tmr_run)
    else $error("pickup dropout did not start dead timer");

  zone_shot_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_DEAD && tmr_exp && zone && ok
    |=> shot_reg == $past(shot_reg) + 3'h1 && tmr_run && !close_cmd
        && state_reg == arz_pkg::ARZ_RECLAIM)
    else $error("zone shot count or reclaim start wrong");

  bkr_open_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_WAITOPN && !breaker_closed && ok
    |=> state_reg == arz_pkg::ARZ_DEAD)
    else $error("open breaker did not start dead time");

  reclaim_ok_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == arz_pkg::ARZ_RECLAIM && tmr_exp && ok && !init_pu && !init_tr
    |=> state_reg == arz_pkg::ARZ_READY && status_reg[arz_pkg::ST_SUCCESS])
    else $error("quiet reclaim did not report success");

  gen_reset_a: assert property (@(posedge clock) disable iff (!rstn)
    gen_reset |=> state_reg == arz_pkg::ARZ_STANDBY && !tmr_run && !mblk_run)
    else $error("general reset did not clear sequencer");
endmodule

// ==== dv/arz_breaker_model.sv ====
// Purpose: Behavioural breaker at the far side of the sequencer
// Assumes: Open and close commands are levels/pulses on the system clock
// Notes:   stuck makes the breaker ignore trip commands (man_open still opens), for supervision tests
`timescale 1ns/1ns
module arz_breaker_model #(
  parameter int DLY = 5
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic trip_cmd,
  input  wire logic close_cmd,
  input  wire logic man_close,
  input  wire logic man_open,
  input  wire logic stuck,
  output logic      breaker_closed
);
  logic [7:0] cnt_reg;
  logic       target_reg;

  // ----------------------------------------------------------------
  // Mechanism travel
  // ----------------------------------------------------------------
  // Contacts move DLY clocks after a trip or close command; manual commands act at once
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      breaker_closed <= 1'b0;
      cnt_reg        <= 8'h00;
      target_reg     <= 1'b0;
    end
    else if (cnt_reg != 8'h00)
    begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h01)
        breaker_closed <= target_reg;
    end
    else if (man_open)
      breaker_closed <= 1'b0;
    else if (man_close)
      breaker_closed <= 1'b1;
    else if (trip_cmd && breaker_closed && !stuck)
    begin
      cnt_reg    <= 8'(DLY);
      target_reg <= 1'b0;
    end
    else if (close_cmd && !breaker_closed)
    begin
      cnt_reg    <= 8'(DLY);
      target_reg <= 1'b1;
    end
  end
endmodule

// ==== dv/arz_seq_bench.sv ====
// Purpose: Self-checking bench for the autoreclose zone-follow sequencer
// Assumes: 4 clocks per ms tick, short timers loaded over the register port
// Notes:   Breaker position comes from arz_breaker_model
`timescale 1ns/1ns
module arz_seq_bench;
  localparam int TC = 4;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        gen_reset = 1'b0;
  logic        ext_block = 1'b0;
  logic [3:0]  pickup = 4'h0;
  logic [3:0]  trip = 4'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        man_close = 1'b0;
  logic        man_open = 1'b0;
  logic        stuck = 1'b0;
  wire logic        breaker_closed;
  wire logic [31:0] rdata;
  wire logic        trip_cmd;
  wire logic        close_cmd;
  wire logic [2:0]  shot_num;
  wire logic        irq;
  int          fail_count = 0;
  int          total_checks = 0;
  int          close_seen = 0;

  always #4 clock = ~clock;
  always @(posedge clock) if (close_cmd === 1'b1) close_seen++;

  arz_seq #(.TICK_CYCLES(TC)) i_dut (.clock(clock), .rstn(rstn), .gen_reset(gen_reset),
    .breaker_closed(breaker_closed), .ext_block(ext_block), .pickup(pickup), .trip(trip),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trip_cmd(trip_cmd),
    .close_cmd(close_cmd), .shot_num(shot_num), .irq(irq));

  arz_breaker_model i_bkr (.clock(clock), .rstn(rstn), .trip_cmd(trip_cmd),
    .close_cmd(close_cmd), .man_close(man_close), .man_open(man_open), .stuck(stuck),
    .breaker_closed(breaker_closed));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string n);
    logic [31:0] v;
    reg_read(a, v);
    chk(n, e, v & m);
  endtask

  // Polls the state register; running out of reads ends the run
  task automatic wait_st(input logic [8:0] s, input int lim);
    logic [31:0] v;
    int          n;
    v = 32'h0;
    n = 0;
    while (v[8:0] !== s && n < lim)
    begin
      reg_read(arz_pkg::ADDR_STATE, v);
      n++;
    end
    chk("state", {23'h0, s}, {23'h0, v[8:0]});
    if (v[8:0] !== s)
      test_done();
  endtask

  task automatic man(input logic c);
    @(posedge clock);
    man_close <= c;
    man_open  <= !c;
    @(posedge clock);
    man_close <= 1'b0;
    man_open  <= 1'b0;
  endtask

  task automatic fault(input logic p, input logic t);
    @(posedge clock);
    pickup <= {3'h0, p};
    trip   <= {3'h0, t};
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd_chk(arz_pkg::ADDR_CTRL, 32'hFF, 32'h05, "ctrl");
    rd_chk(arz_pkg::ADDR_DEAD0, 32'hFFFFFFFF, 32'h1F4, "dead0");
    rd_chk(arz_pkg::ADDR_MBLK, 32'hFFFFFFFF, 32'h3E8, "mblk");
    rd_chk(arz_pkg::ADDR_RECL, 32'hFFFFFFFF, 32'h2710, "recl");
    rd_chk(arz_pkg::ADDR_INIT, 32'hFFFFFFFF, 32'hFFFF, "init");
    rd_chk(arz_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h0, "mask");
    rd_chk(arz_pkg::ADDR_STATE, 32'h1FF, 32'h001, "state");
    reg_write(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++)
      reg_write(arz_pkg::ADDR_DEAD0 + 8'(4 * i), 32'h3);
    reg_write(arz_pkg::ADDR_MBLK, 32'h5);
    reg_write(arz_pkg::ADDR_RECL, 32'h6);
    $display("t_regs done");
  endtask

  task automatic t_trip_blk;
    man(1'b1);
    fault(1'b1, 1'b1);
    repeat (2) @(posedge clock);
    chk("trip_cmd", 32'h1, {31'h0, trip_cmd});
    rd_chk(arz_pkg::ADDR_STATE, 32'h2000, 32'h2000, "blk_run");
    fault(1'b0, 1'b0);
    wait_st(arz_pkg::ARZ_STANDBY, 40);
    chk("breaker", 32'h0, {31'h0, breaker_closed});
    rd_chk(arz_pkg::ADDR_STATUS, 32'h6, 32'h0, "no_lockout");
    $display("t_trip_blk done");
  endtask

  task automatic t_manual;
    man(1'b1);
    rd_chk(arz_pkg::ADDR_STATE, 32'h1FF, 32'h002, "manblk");
    wait_st(arz_pkg::ARZ_READY, 20);
    $display("t_manual done");
  endtask

  task automatic t_normal;
    reg_write(arz_pkg::ADDR_MASK, 32'h1);
    fault(1'b1, 1'b1);
    wait_st(arz_pkg::ARZ_DEAD, 100);
    fault(1'b0, 1'b0);
    wait_st(arz_pkg::ARZ_READY, 100);
    chk("close_seen", 32'h1, 32'(close_seen));
    rd_chk(arz_pkg::ADDR_STATUS, 32'hF, 32'h9, "status");
    chk("irq_set", 32'h1, {31'h0, irq});
    reg_write(arz_pkg::ADDR_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk("irq_masked", 32'h0, {31'h0, irq});
    reg_write(arz_pkg::ADDR_STATUS, 32'hF);
    rd_chk(arz_pkg::ADDR_STATUS, 32'hF, 32'h0, "status_clr");
    $display("t_normal done");
  endtask

  task automatic t_zone;
    int c0;
    c0 = close_seen;
    reg_write(arz_pkg::ADDR_CTRL, 32'h0B);
    for (int k = 0; k < 2; k++)
    begin
      fault(1'b1, 1'b0);
      wait_st(arz_pkg::ARZ_RUN, 20);
      chk("shot_run", 32'h0, {29'h0, shot_num});
      fault(1'b0, 1'b0);
      wait_st(arz_pkg::ARZ_RECLAIM, 30);
      chk("shot", 32'h1, {29'h0, shot_num});
      chk("no_close", 32'(c0), 32'(close_seen));
      chk("bkr", 32'h1, {31'h0, breaker_closed});
      if (k == 0)
      begin
        wait_st(arz_pkg::ARZ_READY, 30);
        rd_chk(arz_pkg::ADDR_STATUS, 32'h9, 32'h9, "zsuccess");
        reg_write(arz_pkg::ADDR_STATUS, 32'hF);
      end
    end
    fault(1'b1, 1'b0);
    wait_st(arz_pkg::ARZ_RUN, 20);
    chk("shot_follow", 32'h1, {29'h0, shot_num});
    fault(1'b0, 1'b0);
    wait_st(arz_pkg::ARZ_RECLAIM, 30);
    chk("shot2", 32'h2, {29'h0, shot_num});
    fault(1'b1, 1'b0);
    wait_st(arz_pkg::ARZ_LOCKOUT, 20);
    rd_chk(arz_pkg::ADDR_STATUS, 32'h6, 32'h6, "failed");
    fault(1'b0, 1'b0);
    $display("t_zone done");
  endtask

  task automatic t_sup;
    reg_write(arz_pkg::ADDR_CTRL, 32'h85);
    @(posedge clock);
    gen_reset <= 1'b1;
    @(posedge clock);
    gen_reset <= 1'b0;
    rd_chk(arz_pkg::ADDR_STATE, 32'h1FF, 32'h001, "gen_rst");
    man(1'b0);
    repeat (4) @(posedge clock);
    man(1'b1);
    // Blocking during the block interval parks the sequencer in standby
    @(posedge clock);
    ext_block <= 1'b1;
    rd_chk(arz_pkg::ADDR_STATE, 32'h1FF, 32'h001, "blocked");
    @(posedge clock);
    ext_block <= 1'b0;
    man(1'b0);
    man(1'b1);
    wait_st(arz_pkg::ARZ_READY, 30);
    stuck <= 1'b1;
    fault(1'b1, 1'b1);
    wait_st(arz_pkg::ARZ_WAITOPN, 20);
    repeat (760) @(posedge clock);
    rd_chk(arz_pkg::ADDR_STATE, 32'h1FF, 32'h010, "waitopn");
    wait_st(arz_pkg::ARZ_LOCKOUT, 40);
    fault(1'b0, 1'b0);
    stuck <= 1'b0;
    $display("t_sup done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_trip_blk();
    t_manual();
    t_normal();
    t_zone();
    t_sup();
    test_done();
  end
endmodule
